// ---- common/sensor_pkg.sv ----
// Shared constants, register map and state types of the sensor core.
package sensor_pkg;
   // Clock and the power-up readiness time.
   localparam int CLK_PERIOD_PS  = 4000;
   localparam int READY_TIME_US  = 3000;
   localparam int READY_CYCLES   = READY_TIME_US * 1000 / CLK_PERIOD_PS;

   // Seven-bit bus address; bit 0 follows the address-select pin.
   localparam logic [6:0] BUS_ADDR_BASE = 7'h40;

   // Register offsets.
   localparam logic [7:0] REG_TEMP_L   = 8'h00;
   localparam logic [7:0] REG_TEMP_H   = 8'h01;
   localparam logic [7:0] REG_HUMID_L  = 8'h02;
   localparam logic [7:0] REG_HUMID_H  = 8'h03;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_IRQ_EN   = 8'h07;
   localparam logic [7:0] REG_TTHR_L   = 8'h0A;
   localparam logic [7:0] REG_TTHR_H   = 8'h0B;
   localparam logic [7:0] REG_HTHR_L   = 8'h0C;
   localparam logic [7:0] REG_HTHR_H   = 8'h0D;
   localparam logic [7:0] REG_IRQ_CFG  = 8'h0E;
   localparam logic [7:0] REG_MEAS_CFG = 8'h0F;
   localparam logic [7:0] REG_ID_FIRST = 8'hFC;

   // Flag and enable fields share bits 7 to 3 of their registers.
   localparam int FLD_FLAG_LSB = 3;
   localparam int FLG_DONE     = 4;
   localparam int FLG_TA       = 3;
   localparam int FLG_TB       = 2;
   localparam int FLG_HA       = 1;
   localparam int FLG_HB       = 0;
   localparam logic [4:0] CMP_MASK = 5'h0F;

   // Interrupt configuration and measurement fields.
   localparam int CFG_SOFT_RST = 7;
   localparam int CFG_PIN_EN   = 2;
   localparam int CFG_POL      = 1;
   localparam int CFG_LATCH    = 0;
   localparam int MEAS_TRIG    = 0;

   // Reset values.
   localparam logic [7:0] RST_ZERO   = 8'h00;
   localparam logic [7:0] RST_THR_HI = 8'hFF;

   typedef enum logic [2:0] {
      BUS_IDLE, BUS_ADDR, BUS_PTR, BUS_WDATA, BUS_ACK, BUS_RDATA, BUS_RACK
   } bus_st_t;

   typedef enum logic {MODE_SLEEP, MODE_MEAS} mode_t;
endpackage

// ---- common/i2c_line_if.sv ----
// Sampled bus line events passed from the line sampler to the core.
`timescale 1ns/10ps
interface i2c_line_if;
   logic scl_rise;
   logic scl_fall;
   logic start_evt;
   logic stop_evt;
   logic sda_lvl;

   modport sampler (output scl_rise, scl_fall, start_evt, stop_evt, sda_lvl);
   modport core    (input  scl_rise, scl_fall, start_evt, stop_evt, sda_lvl);
endinterface

// ---- rtl/i2c_line_sampler.sv ----
// Synchroniser and edge finder for the serial clock and data pins.
`timescale 1ns/10ps
module i2c_line_sampler (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic scl_pin,
   input  wire logic sda_pin,
   i2c_line_if.sampler ln
);
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic       scl_prev_ff;
   logic       sda_prev_ff;

   // Two flops per pin; only the second stage feeds any logic.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_pin};
         sda_sync_ff <= {sda_sync_ff[0], sda_pin};
      end
   end

   // Previous settled levels, idle bus is high.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_prev_ff <= scl_sync_ff[1];
         sda_prev_ff <= sda_sync_ff[1];
      end
   end

   // Data moving while the clock is high marks start and stop.
   assign ln.scl_rise  = scl_sync_ff[1] & ~scl_prev_ff;
   assign ln.scl_fall  = ~scl_sync_ff[1] & scl_prev_ff;
   assign ln.start_evt = scl_sync_ff[1] & scl_prev_ff &
                         sda_prev_ff & ~sda_sync_ff[1];
   assign ln.stop_evt  = scl_sync_ff[1] & scl_prev_ff &
                         ~sda_prev_ff & sda_sync_ff[1];
   assign ln.sda_lvl   = sda_sync_ff[1];
endmodule

// ---- rtl/sensor_core.sv ----
// Sensor digital core: bus target, register file, modes and alarm pin.
`timescale 1ns/10ps
module sensor_core #(
   parameter int         READY_CYCLES = sensor_pkg::READY_CYCLES,
   parameter logic [7:0] ID_BYTE0     = 8'h5A, // Arbitrary value.
   parameter logic [7:0] ID_BYTE1     = 8'hA5, // Arbitrary value.
   parameter logic [7:0] ID_BYTE2     = 8'h3C, // Arbitrary value.
   parameter logic [7:0] ID_BYTE3     = 8'hC3  // Arbitrary value.
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output wire logic        sda_out,
   output wire logic        sda_oe,
   input  wire logic        addr_sel,
   output wire logic        ready_irq_pin_out,
   output wire logic        ready_irq_pin_oe,
   output wire logic        meas_start,
   input  wire logic        conv_done,
   input  wire logic [15:0] temp_result,
   input  wire logic [15:0] humid_result,
   output wire logic        meas_active,
   output wire logic        sensor_ready
);
   localparam int RCW = $clog2(READY_CYCLES + 1);

   // Refuse a power-up delay the counter cannot express.
   if (READY_CYCLES < 1) begin : g_chk
      $error("READY_CYCLES must be at least one");
   end

   i2c_line_if ln ();

   i2c_line_sampler u_sampler (
      .clk     (clk),
      .arst_n  (arst_n),
      .scl_pin (scl_in),
      .sda_pin (sda_in),
      .ln      (ln.sampler)
   );

   sensor_pkg::bus_st_t st_ff;
   sensor_pkg::bus_st_t ack_next_ff;
   sensor_pkg::mode_t   mode_ff;
   logic [3:0]      bit_cnt_ff;
   logic [7:0]      shreg_ff;
   logic [7:0]      tx_ff;
   logic [7:0]      ptr_ff;
   logic            sda_oe_ff;
   logic            mack_ff;
   logic [1:0]      addr_sync_ff;
   logic [7:0]      cfg_ff [5:15];
   logic [15:0]     temp_ff;
   logic [15:0]     humid_ff;
   logic [4:0]      flags_ff;
   logic [RCW-1:0]  rdy_cnt_ff;
   logic            ready_ff;
   logic            meas_start_ff;
   logic            irq_out_ff;
   logic            irq_oe_ff;

   // Pointer decode used for acceptance and for write access.
   function automatic logic reg_used(input logic [7:0] a);
      return (a <= sensor_pkg::REG_MEAS_CFG) ||
             (a >= sensor_pkg::REG_ID_FIRST);
   endfunction

   function automatic logic reg_writable(input logic [7:0] a);
      return (a >= sensor_pkg::REG_STATUS) &&
             (a <= sensor_pkg::REG_MEAS_CFG);
   endfunction

   // Read data for one register offset.
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         sensor_pkg::REG_TEMP_L:  v = temp_ff[7:0];
         sensor_pkg::REG_TEMP_H:  v = temp_ff[15:8];
         sensor_pkg::REG_HUMID_L: v = humid_ff[7:0];
         sensor_pkg::REG_HUMID_H: v = humid_ff[15:8];
         sensor_pkg::REG_STATUS:  v = {flags_ff, 3'h0};
         8'hFC:                   v = ID_BYTE0;
         8'hFD:                   v = ID_BYTE1;
         8'hFE:                   v = ID_BYTE2;
         8'hFF:                   v = ID_BYTE3;
         default: begin
            if (a <= sensor_pkg::REG_MEAS_CFG && a > sensor_pkg::REG_STATUS)
               v = cfg_ff[a[3:0]];
         end
      endcase
      return v;
   endfunction

   // Byte-level events of the bus engine.
   logic       byte_done;
   logic       rx_end;
   logic       addr_hit;
   logic       load_rd;
   logic       wr_stb;
   logic       stat_rd;
   logic       soft_rst;
   logic       trig;
   logic [7:0] irq_cfg;
   logic [4:0] irq_en;
   logic [7:0] rd_now;

   assign byte_done = ln.scl_fall && bit_cnt_ff == 4'h8;
   assign rx_end    = byte_done && (st_ff == sensor_pkg::BUS_ADDR ||
                      st_ff == sensor_pkg::BUS_PTR ||
                      st_ff == sensor_pkg::BUS_WDATA);
   assign addr_hit  = shreg_ff[7:1] ==
                      {sensor_pkg::BUS_ADDR_BASE[6:1], addr_sync_ff[1]};
   assign load_rd   = ln.scl_fall &&
                      ((st_ff == sensor_pkg::BUS_ACK &&
                        ack_next_ff == sensor_pkg::BUS_RDATA) ||
                       (st_ff == sensor_pkg::BUS_RACK && mack_ff));
   assign wr_stb    = rx_end && st_ff == sensor_pkg::BUS_WDATA &&
                      reg_writable(ptr_ff);
   assign stat_rd   = load_rd && ptr_ff == sensor_pkg::REG_STATUS;
   assign soft_rst  = wr_stb && ptr_ff == sensor_pkg::REG_IRQ_CFG &&
                      shreg_ff[sensor_pkg::CFG_SOFT_RST];
   assign trig      = wr_stb && ptr_ff == sensor_pkg::REG_MEAS_CFG &&
                      shreg_ff[sensor_pkg::MEAS_TRIG];
   assign irq_cfg   = cfg_ff[sensor_pkg::REG_IRQ_CFG[3:0]];
   assign irq_en    = cfg_ff[sensor_pkg::REG_IRQ_EN[3:0]][7:3];
   assign rd_now    = rd_byte(ptr_ff);

   // Address-select pin is static, but still synchronised before use.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         addr_sync_ff <= 2'h0;
      else
         addr_sync_ff <= {addr_sync_ff[0], addr_sel};
   end

   // Bus state machine. The engine only answers; it never drives the
   // clock and never begins a transfer on its own.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff       <= sensor_pkg::BUS_IDLE;
         ack_next_ff <= sensor_pkg::BUS_IDLE;
         bit_cnt_ff  <= 4'h0;
         shreg_ff    <= 8'h00;
         tx_ff       <= 8'h00;
         sda_oe_ff   <= 1'b0;
         mack_ff     <= 1'b0;
      end else if (ln.start_evt) begin
         st_ff      <= sensor_pkg::BUS_ADDR;
         bit_cnt_ff <= 4'h0;
         sda_oe_ff  <= 1'b0;
      end else if (ln.stop_evt) begin
         st_ff     <= sensor_pkg::BUS_IDLE;
         sda_oe_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            sensor_pkg::BUS_IDLE: ;
            sensor_pkg::BUS_ADDR, sensor_pkg::BUS_PTR,
            sensor_pkg::BUS_WDATA: begin
               if (ln.scl_rise) begin
                  shreg_ff   <= {shreg_ff[6:0], ln.sda_lvl};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_ff <= 4'h0;
                  st_ff      <= sensor_pkg::BUS_ACK;
                  if (st_ff == sensor_pkg::BUS_ADDR) begin
                     sda_oe_ff   <= addr_hit;
                     ack_next_ff <= !addr_hit ? sensor_pkg::BUS_IDLE :
                                    shreg_ff[0] ? sensor_pkg::BUS_RDATA :
                                    sensor_pkg::BUS_PTR;
                  end else if (st_ff == sensor_pkg::BUS_PTR) begin
                     sda_oe_ff   <= reg_used(shreg_ff);
                     ack_next_ff <= reg_used(shreg_ff) ?
                                    sensor_pkg::BUS_WDATA :
                                    sensor_pkg::BUS_IDLE;
                  end else begin
                     sda_oe_ff   <= reg_writable(ptr_ff);
                     ack_next_ff <= sensor_pkg::BUS_WDATA;
                  end
               end
            end
            sensor_pkg::BUS_ACK: begin
               if (ln.scl_fall) begin
                  st_ff <= ack_next_ff;
                  if (load_rd) begin
                     tx_ff     <= rd_now;
                     sda_oe_ff <= ~rd_now[7];
                  end else
                     sda_oe_ff <= 1'b0;
               end
            end
            sensor_pkg::BUS_RDATA: begin
               if (ln.scl_rise)
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               else if (byte_done) begin
                  bit_cnt_ff <= 4'h0;
                  sda_oe_ff  <= 1'b0;
                  st_ff      <= sensor_pkg::BUS_RACK;
               end else if (ln.scl_fall) begin
                  tx_ff     <= {tx_ff[6:0], 1'b0};
                  sda_oe_ff <= ~tx_ff[6];
               end
            end
            sensor_pkg::BUS_RACK: begin
               if (ln.scl_rise)
                  mack_ff <= ~ln.sda_lvl;
               else if (ln.scl_fall) begin
                  if (mack_ff) begin
                     st_ff     <= sensor_pkg::BUS_RDATA;
                     tx_ff     <= rd_now;
                     sda_oe_ff <= ~rd_now[7];
                  end else
                     st_ff <= sensor_pkg::BUS_IDLE;
               end
            end
         endcase
      end
   end

   // Register pointer: loaded by the first write byte, stepped after
   // every data byte in either direction.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         ptr_ff <= 8'h00;
      else if (rx_end && st_ff == sensor_pkg::BUS_PTR &&
               reg_used(shreg_ff))
         ptr_ff <= shreg_ff;
      else if (load_rd || (rx_end && st_ff == sensor_pkg::BUS_WDATA))
         ptr_ff <= ptr_ff + 8'h01;
   end

   // Writable configuration bytes. Soft reset bit is a command and does
   // not stay set; the trigger bit self-clears for the same reason.
   generate
      for (genvar i = 5; i <= 15; i++) begin : g_cfg
         localparam logic [7:0] RST_V =
            (i == 11 || i == 13) ? sensor_pkg::RST_THR_HI :
                                   sensor_pkg::RST_ZERO;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n)
               cfg_ff[i] <= RST_V;
            else if (soft_rst)
               cfg_ff[i] <= RST_V;
            else if (wr_stb && ptr_ff == 8'(i))
               cfg_ff[i] <= (i == 14) ? {1'b0, shreg_ff[6:0]} :
                            (i == 15) ? {shreg_ff[7:1], 1'b0} :
                            shreg_ff;
         end
      end
   endgenerate

   // Power-up readiness counter; triggers before it ends are ignored.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdy_cnt_ff <= '0;
         ready_ff   <= 1'b0;
      end else if (!ready_ff) begin
         rdy_cnt_ff <= rdy_cnt_ff + RCW'(1);
         if (rdy_cnt_ff == RCW'(READY_CYCLES - 1))
            ready_ff <= 1'b1;
      end
   end

   // Sleep and measurement sequencing; the converter answers conv_done.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff       <= sensor_pkg::MODE_SLEEP;
         meas_start_ff <= 1'b0;
      end else begin
         meas_start_ff <= 1'b0;
         unique case (mode_ff)
            sensor_pkg::MODE_SLEEP: begin
               if (trig && ready_ff && !soft_rst) begin
                  mode_ff       <= sensor_pkg::MODE_MEAS;
                  meas_start_ff <= 1'b1;
               end
            end
            sensor_pkg::MODE_MEAS: begin
               if (conv_done || soft_rst)
                  mode_ff <= sensor_pkg::MODE_SLEEP;
            end
         endcase
      end
   end

   // Result registers take the conversion as it finishes.
   logic conv_evt;
   assign conv_evt = conv_done && mode_ff == sensor_pkg::MODE_MEAS;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         temp_ff  <= 16'h0000;
         humid_ff <= 16'h0000;
      end else if (conv_evt) begin
         temp_ff  <= temp_result;
         humid_ff <= humid_result;
      end
   end

   // Threshold comparisons on the upper result byte.
   logic [4:0] cond;
   logic [4:0] set_v;
   assign cond[sensor_pkg::FLG_DONE] = 1'b1;
   assign cond[sensor_pkg::FLG_TA] =
      temp_result[15:8] > cfg_ff[sensor_pkg::REG_TTHR_H[3:0]];
   assign cond[sensor_pkg::FLG_TB] =
      temp_result[15:8] < cfg_ff[sensor_pkg::REG_TTHR_L[3:0]];
   assign cond[sensor_pkg::FLG_HA] =
      humid_result[15:8] > cfg_ff[sensor_pkg::REG_HTHR_H[3:0]];
   assign cond[sensor_pkg::FLG_HB] =
      humid_result[15:8] < cfg_ff[sensor_pkg::REG_HTHR_L[3:0]];
   assign set_v = conv_evt ? (irq_en & cond) : 5'h00;

   // Status flags. A set in the cycle of a status read wins, so no
   // event is lost to a read that raced it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         flags_ff <= 5'h00;
      else if (soft_rst)
         flags_ff <= 5'h00;
      else if (irq_cfg[sensor_pkg::CFG_LATCH] && conv_evt)
         flags_ff <= (set_v & sensor_pkg::CMP_MASK) |
                     ((flags_ff & ~{5{stat_rd}}) | set_v) &
                     ~sensor_pkg::CMP_MASK;
      else
         flags_ff <= (flags_ff & ~{5{stat_rd}}) | set_v;
   end

   // One source steers the pin, chosen by fixed priority.
   function automatic logic pick_src(input logic [4:0] en,
                                     input logic [4:0] fl);
      logic r;
      r = fl[sensor_pkg::FLG_DONE];
      if (en[sensor_pkg::FLG_TA])
         r = fl[sensor_pkg::FLG_TA];
      else if (en[sensor_pkg::FLG_TB])
         r = fl[sensor_pkg::FLG_TB];
      else if (en[sensor_pkg::FLG_HA])
         r = fl[sensor_pkg::FLG_HA];
      else if (en[sensor_pkg::FLG_HB])
         r = fl[sensor_pkg::FLG_HB];
      return r;
   endfunction

   // Pin output flops; the level follows the configured polarity.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_out_ff <= 1'b1;
         irq_oe_ff  <= 1'b0;
      end else begin
         irq_out_ff <= irq_cfg[sensor_pkg::CFG_POL] ~^
                       pick_src(irq_en, flags_ff) ? 1'b1 : 1'b0;
         irq_oe_ff  <= irq_cfg[sensor_pkg::CFG_PIN_EN];
      end
   end

   // Open-drain data line: only ever pulls low.
   assign sda_out           = 1'b0;
   assign sda_oe            = sda_oe_ff;
   assign ready_irq_pin_out = irq_out_ff;
   assign ready_irq_pin_oe  = irq_oe_ff;
   assign meas_start        = meas_start_ff;
   assign meas_active       = mode_ff == sensor_pkg::MODE_MEAS;
   assign sensor_ready      = ready_ff;
endmodule

// ---- sim/sensor_core_sva.sv ----
// Concurrent checks on converter handshake, readiness and bus pins.
`timescale 1ns/10ps
module sensor_core_sva #(
   parameter int READY_CYCLES = 20
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sda_out,
   input wire logic meas_start,
   input wire logic meas_active,
   input wire logic conv_done,
   input wire logic sensor_ready,
   input wire logic ready_irq_pin_out
);
   int unsigned up_cnt_ff;

   // Edges since reset release; saturates so the late check fires once.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         up_cnt_ff <= 0;
      end else if (up_cnt_ff < READY_CYCLES + 4) begin
         up_cnt_ff <= up_cnt_ff + 1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   // A conversion that finishes while the core is measuring.
   sequence conv_end_s;
      meas_active && conv_done;
   endsequence

   sda_low_only_a: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
   start_ready_a: assert property (meas_start |-> sensor_ready)
      else $error("trigger before ready");
   start_pulse_a: assert property (meas_start |=> !meas_start)
      else $error("trigger pulse too long");
   enter_meas_a: assert property (meas_start |-> ##[0:2] meas_active)
      else $error("no measurement mode");
   leave_meas_a: assert property (conv_end_s |-> ##[1:2] !meas_active)
      else $error("no return to sleep");
   trig_only_a: assert property ($rose(meas_active) |->
      meas_start || $past(meas_start))
      else $error("left sleep untriggered");
   ready_late_a: assert property ((up_cnt_ff == READY_CYCLES + 3)
      |-> sensor_ready)
      else $error("ready too late");
   ready_early_a: assert property ((up_cnt_ff + 2 < READY_CYCLES)
      |-> !sensor_ready)
      else $error("ready too early");
   stray_done_a: assert property ((!meas_active && conv_done)
      |=> $stable(ready_irq_pin_out))
      else $error("stray conversion taken");
endmodule

bind sensor_core sensor_core_sva #(.READY_CYCLES(READY_CYCLES)) u_sva (
   .clk(clk), .arst_n(arst_n), .sda_out(sda_out),
   .meas_start(meas_start), .meas_active(meas_active),
   .conv_done(conv_done), .sensor_ready(sensor_ready),
   .ready_irq_pin_out(ready_irq_pin_out));

// ---- sim/i2c_ctrl_model.sv ----
// Bus controller model: drives the serial clock, pulls data low.
`timescale 1ns/10ps
module i2c_ctrl_model (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   localparam real Q = 8.0; // Quarter of the 32 ns bus clock period.

   // The bus idles released, with the clock standing high.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Data set in the low phase, sampled at the end of the high phase.
   task automatic bit_x(input logic v, output logic s);
      sda_low = ~v;
      #(Q);
      scl = 1'b1;
      #(2 * Q);
      s = sda;
      scl = 1'b0;
      #(Q);
   endtask

   // Long low phase first, so the target's release settles.
   task automatic start_c();
      sda_low = 1'b0;
      #(4 * Q);
      scl = 1'b1;
      #(2 * Q);
      sda_low = 1'b1;
      #(2 * Q);
      scl = 1'b0;
      #(Q);
   endtask

   // Data rises while the clock is high.
   task automatic stop_c();
      sda_low = 1'b1;
      #(Q);
      scl = 1'b1;
      #(2 * Q);
      sda_low = 1'b0;
      #(4 * Q);
   endtask

   // Byte out MSB first; ack is 1 when the target pulls low.
   task automatic byte_w(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], s);
      end
      bit_x(1'b1, s);
      ack = ~s;
   endtask

   // Byte in MSB first; the last one gets a NACK.
   task automatic byte_r(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         b[i] = s;
      end
      bit_x(last, s);
   endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the sensor core over its serial bus.
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
   localparam int RC = 20;
   logic        clk;
   logic        arst_n;
   logic        conv_done;
   logic        seen;
   logic [15:0] t_res;
   logic [15:0] h_res;
   wire logic   scl;
   wire logic   sda_low;
   wire logic   sda_oe;
   wire logic   sda_out;
   wire logic   irq_o;
   wire logic   irq_oe;
   wire logic   mst;
   wire logic   mact;
   wire logic   rdy;
   wire logic   sda;
   int          err_count;
   int          n_compared;

   // Open-drain data line with a pull-up.
   assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

   // Address strap tied low for the whole run.
   sensor_core #(.READY_CYCLES(RC)) u_dut (
      .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(1'b0),
      .ready_irq_pin_out(irq_o), .ready_irq_pin_oe(irq_oe),
      .meas_start(mst), .conv_done(conv_done), .temp_result(t_res),
      .humid_result(h_res), .meas_active(mact), .sensor_ready(rdy));
   i2c_ctrl_model u_m (.scl(scl), .sda_low(sda_low), .sda(sda));

   // Clock source at 250 MHz.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // The trigger pulse lasts one cycle, so catch it here.
   always @(posedge clk) if (mst) seen <= 1'b1;

   // Watchdog well beyond the expected run length.
   initial begin
      #300000;
      err_count++;
      stop_test();
   end

   task automatic stop_test();
      if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Write transfer; the byte after the address is the pointer.
   task automatic wq(input logic [7:0] q[$], input logic ea);
      logic a;
      logic ok;
      ok = 1'b1;
      u_m.start_c();
      foreach (q[i]) begin
         if (ok) begin
            u_m.byte_w(q[i], a);
            ok = a;
         end
      end
      u_m.stop_c();
      `CHK(ok, ea)
   endtask

   // Pointer write, repeated start, then a read of e.size() bytes.
   task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
      logic a;
      logic [7:0] b;
      u_m.start_c();
      u_m.byte_w(8'h80, a);
      u_m.byte_w(p, a);
      u_m.start_c();
      u_m.byte_w(8'h81, a);
      foreach (e[i]) begin
         u_m.byte_r(i == e.size() - 1, b);
         `CHK(b, e[i])
      end
      u_m.stop_c();
   endtask

   // Trigger a conversion and answer it as the converter would.
   task automatic ms(input logic [15:0] t, input logic [15:0] h);
      seen = 1'b0;
      wq('{8'h80, 8'h0F, 8'h01}, 1'b1);
      `CHK(seen, 1'b1)
      @(posedge clk);
      `CHK(mact, 1'b1)
      t_res <= t;
      h_res <= h;
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(mact, 1'b0)
   endtask

   // Main sequence; no trigger before the ready time.
   initial begin
      arst_n = 1'b0;
      conv_done = 1'b0;
      t_res = 16'h0000;
      h_res = 16'h0000;
      repeat (5) @(posedge clk);
      `CHK({sda_oe, irq_oe, mact, rdy}, 4'h0)
      arst_n <= 1'b1;
      repeat (RC + 4) @(posedge clk);
      `CHK(rdy, 1'b1)
      wq('{8'h80, 8'h0A, 8'h40, 8'hC0, 8'h40, 8'hC0}, 1'b1);
      rd(8'h0A, '{8'h40, 8'hC0, 8'h40, 8'hC0});
      wq('{8'h82}, 1'b0);
      wq('{8'h80, 8'h10}, 1'b0);
      wq('{8'h80, 8'hFC, 8'h55}, 1'b0);
      wq('{8'h80, 8'h07, 8'h80}, 1'b1);
      wq('{8'h80, 8'h0E, 8'h06}, 1'b1);
      ms(16'h8000, 16'h8000);
      `CHK({irq_o, irq_oe}, 2'b11)
      rd(8'h04, '{8'h80});
      `CHK(irq_o, 1'b0)
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(irq_o, 1'b0)
      wq('{8'h80, 8'h07, 8'hA8}, 1'b1);
      ms(16'h8000, 16'h1000);
      `CHK(irq_o, 1'b0)
      rd(8'h04, '{8'h88});
      wq('{8'h80, 8'h07, 8'hF8}, 1'b1);
      ms(16'h1000, 16'hD000);
      `CHK(irq_o, 1'b0)
      rd(8'h04, '{8'hB0});
      wq('{8'h80, 8'h07, 8'hC0}, 1'b1);
      ms(16'hD000, 16'h8000);
      `CHK(irq_o, 1'b1)
      ms(16'h8000, 16'h8000);
      rd(8'h04, '{8'hC0});
      wq('{8'h80, 8'h0E, 8'h07}, 1'b1);
      ms(16'hD000, 16'h8000);
      ms(16'h8000, 16'h8000);
      rd(8'h04, '{8'h80});
      wq('{8'h80, 8'h0E, 8'h04}, 1'b1);
      wq('{8'h80, 8'h07, 8'h80}, 1'b1);
      ms(16'h8000, 16'h8000);
      `CHK(irq_o, 1'b0)
      rd(8'h04, '{8'h80});
      `CHK(irq_o, 1'b1)
      stop_test();
   end
endmodule
